// [hw/fssp_map.svh]
// Purpose : constants of the framed synchronous serial port
// Assumes : included by bare name; guarded against double inclusion
// Notes   : widths, counts, pin bit positions and reset values only
`ifndef FSSP_MAP_SVH
`define FSSP_MAP_SVH

`define FSSP_WORD_W      16
`define FSSP_BYTE_W      8
`define FSSP_CNT_W       5
`define FSSP_LEN_WORD    5'h10
`define FSSP_LEN_BYTE    5'h08
`define FSSP_FIFO_DEPTH  8
`define FSSP_BIT_DIV     4
`define FSSP_SYNC_N      5
`define FSSP_PIN_TCLK    0
`define FSSP_PIN_TFS     1
`define FSSP_PIN_RCLK    2
`define FSSP_PIN_RFS     3
`define FSSP_PIN_DIN     4
`define FSSP_TRANSMIT_READY_FLAG_RST    1'b1
`define FSSP_RECEIVE_READY_FLAG_RST    1'b0

`endif

// [hw/fssp_pkg.sv]
// Purpose : shared types of the framed synchronous serial port
// Assumes : fssp_map.svh on the include path
// Notes   : state codes are gray along the usual path, except receive SHIFT back to IDLE and transmit IDLE to ARM under outside frame sync
package fssp_pkg;
`include "fssp_map.svh"

    typedef logic [`FSSP_WORD_W-1:0] fssp_word_t;
    typedef logic [`FSSP_CNT_W-1:0]  fssp_cnt_t;

    typedef enum logic [1:0] {
        FSSP_TX_IDLE  = 2'h0,
        FSSP_TX_SYNC  = 2'h1,
        FSSP_TX_ARM   = 2'h3,
        FSSP_TX_SHIFT = 2'h2
    } fssp_tx_state_t;

    typedef enum logic [1:0] {
        FSSP_RX_IDLE  = 2'h0,
        FSSP_RX_ARM   = 2'h1,
        FSSP_RX_SHIFT = 2'h3
    } fssp_rx_state_t;

endpackage

// [hw/fssp_fifo.sv]
// Purpose : small first-in first-out buffer with valid/ready on both sides
// Assumes : single clock, synchronous active-high reset
// Notes   : depth must be a power of two; full and empty come from the count
`timescale 1ns/1ps
module fssp_fifo #(
    parameter int W = 16,
    parameter int D = 8
) (
    input  wire logic         clk,       // system clock
    input  wire logic         rst,       // synchronous reset
    input  wire logic         in_valid,  // producer offers a word
    output logic              in_ready,  // room for a word
    input  wire logic [W-1:0] in_data,   // offered word
    output logic              out_valid, // a word is waiting
    input  wire logic         out_ready, // consumer takes the word
    output logic [W-1:0]      out_data   // oldest word
);
    localparam int AW = $clog2(D);

    logic [W-1:0]  mem_q [D];
    logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
    logic [AW:0]   cnt_q, cnt_d;
    logic          push, pop;

    assign in_ready  = (cnt_q != D[AW:0]);
    assign out_valid = (cnt_q != '0);
    assign out_data  = mem_q[rd_q];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb begin
        wr_d  = push ? wr_q + 1'b1 : wr_q;
        rd_d  = pop ? rd_q + 1'b1 : rd_q;
        cnt_d = cnt_q;
        if (push && !pop) begin
            cnt_d = cnt_q + 1'b1;
        end else if (pop && !push) begin
            cnt_d = cnt_q - 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            wr_q  <= wr_d;
            rd_q  <= rd_d;
            cnt_q <= cnt_d;
        end
    end

    // storage needs no reset; only words behind the count are ever read
    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end
endmodule

// [hw/fssp_port.sv]
// Purpose : double-buffered full-duplex framed synchronous serial port
// Assumes : clk is the machine clock (40 MHz); all pins are asynchronous to it
// Notes   : holding registers are reached through plain strobes and ports
`timescale 1ns/1ps
`include "fssp_map.svh"
module fssp_port (
    input  wire logic                 clk,                    // machine clock
    input  wire logic                 rst,                    // synchronous reset, active high
    input  wire logic                 cfg_fmt_8bit,           // 1: 8-bit packets, 0: 16-bit
    input  wire logic                 cfg_burst,              // 1: burst framing, 0: continuous
    input  wire logic                 cfg_int_clock,          // 1: port makes transmit bit clock
    input  wire logic                 cfg_int_fsync,          // 1: port makes transmit frame sync
    input  wire logic                 tx_enable,              // 0 halts the transmitter
    input  wire logic                 rx_enable,              // 0 halts the receiver
    input  wire logic                 tx_wr,                  // write strobe, transmit holding register
    input  wire fssp_pkg::fssp_word_t tx_wdata,               // data written
    input  wire logic                 rx_rd,                  // read strobe, receive holding register
    output fssp_pkg::fssp_word_t      receive_holding_reg,    // received packet, passed on oldest first from the buffer
    output logic                      transmit_ready_flag,    // transmit holding may be written
    output logic                      receive_ready_flag,     // receive holding holds new data
    output logic                      transmit_irq,           // one-cycle pulse per transmit copy
    output logic                      receive_irq,            // one-cycle pulse per receive copy
    output logic                      tx_shift_empty,         // shift register empty: transmitter in IDLE or SYNC
    output logic                      rx_overrun,             // packet lost, buffer full
    input  wire logic                 transmit_bit_clock_i,   // pin level in
    output logic                      transmit_bit_clock_o,   // pin level out
    output logic                      transmit_bit_clock_oe,  // pin driven
    input  wire logic                 transmit_frame_sync_i,  // pin level in
    output logic                      transmit_frame_sync_o,  // pin level out
    output logic                      transmit_frame_sync_oe, // pin driven
    output logic                      serial_out_pin_o,       // serial data out
    output logic                      serial_out_pin_oe,      // serial data driven
    input  wire logic                 receive_bit_clock,      // receive clock pin
    input  wire logic                 receive_frame_sync,     // receive frame pin
    input  wire logic                 serial_in_pin           // serial data in
);
    import fssp_pkg::*;

    // ----------------------------------------------------------------
    // pin synchronisers and edge detect
    // ----------------------------------------------------------------
    logic [`FSSP_SYNC_N-1:0] pin_raw, sync1_q, sync2_q, prev_q;

    assign pin_raw = {serial_in_pin, receive_frame_sync, receive_bit_clock,
                      transmit_frame_sync_i, transmit_bit_clock_i};

    genvar gi;
    generate
        for (gi = 0; gi < `FSSP_SYNC_N; gi++) begin : g_sync
            always_ff @(posedge clk) begin
                if (rst) begin
                    sync1_q[gi] <= 1'b0;
                    sync2_q[gi] <= 1'b0;
                    prev_q[gi]  <= 1'b0;
                end else begin
                    sync1_q[gi] <= pin_raw[gi];
                    sync2_q[gi] <= sync1_q[gi];
                    prev_q[gi]  <= sync2_q[gi];
                end
            end
        end
    endgenerate

    logic      ext_tx_rise, ext_tx_fall, rx_fall, rfs, tfs_ext, din;
    fssp_cnt_t pkt_len;

    assign ext_tx_rise = sync2_q[`FSSP_PIN_TCLK] && !prev_q[`FSSP_PIN_TCLK];
    assign ext_tx_fall = !sync2_q[`FSSP_PIN_TCLK] && prev_q[`FSSP_PIN_TCLK];
    assign rx_fall     = !sync2_q[`FSSP_PIN_RCLK] && prev_q[`FSSP_PIN_RCLK];
    assign rfs         = sync2_q[`FSSP_PIN_RFS];
    assign tfs_ext     = sync2_q[`FSSP_PIN_TFS];
    assign din         = sync2_q[`FSSP_PIN_DIN];
    assign pkt_len     = cfg_fmt_8bit ? `FSSP_LEN_BYTE : `FSSP_LEN_WORD;

    // ----------------------------------------------------------------
    // transmit side
    // ----------------------------------------------------------------
    fssp_tx_state_t tx_st_q, tx_st_d;
    fssp_word_t     thold_q, thold_d, tsh_q, tsh_d;
    fssp_cnt_t      tbits_q, tbits_d;
    logic           tfull_q, tfull_d, transmit_ready_flag_q, transmit_ready_flag_d, xirq_q, xirq_d;
    logic           fsseen_q, fsseen_d, div_q, div_d, clkint_q, clkint_d;
    logic           fs_q, fs_d, dout_q, dout_d, doe_q, doe_d;
    logic           clkoe_q, clkoe_d, fsoe_q, fsoe_d, tsempty_q, tsempty_d;
    logic           tx_rise, tx_fall;
    fssp_word_t     thold_aligned;

    // internal bit clock toggles every second machine clock: clk/4
    assign tx_rise = cfg_int_clock ? (div_q && !clkint_q) : ext_tx_rise;
    assign tx_fall = cfg_int_clock ? (div_q && clkint_q) : ext_tx_fall;
    // 8-bit packets are left-aligned so the first bit is always bit 15
    assign thold_aligned = cfg_fmt_8bit ? {thold_q[`FSSP_BYTE_W-1:0], {`FSSP_BYTE_W{1'b0}}} : thold_q;

    always_comb begin
        tx_st_d   = tx_st_q;
        thold_d   = thold_q;
        tsh_d     = tsh_q;
        tbits_d   = tbits_q;
        tfull_d   = tfull_q;
        transmit_ready_flag_d    = transmit_ready_flag_q;
        xirq_d    = 1'b0;
        fsseen_d  = fsseen_q;
        fs_d      = fs_q;
        dout_d    = dout_q;
        doe_d     = doe_q;
        div_d     = !div_q;
        clkint_d  = div_q ? !clkint_q : clkint_q;
        clkoe_d   = cfg_int_clock;
        fsoe_d    = cfg_int_fsync;
        if (tx_wr) begin
            thold_d = tx_wdata;
            tfull_d = 1'b1;
            transmit_ready_flag_d  = 1'b0;
        end
        if (!tx_enable) begin
            tx_st_d  = FSSP_TX_IDLE;
            fs_d     = 1'b0;
            doe_d    = 1'b0;
            fsseen_d = 1'b0;
        end else begin
            case (tx_st_q)
                FSSP_TX_IDLE: begin
                    if (tfull_q) begin
                        if (cfg_int_fsync) begin
                            if (tx_rise) begin
                                fs_d    = 1'b1;
                                tx_st_d = FSSP_TX_SYNC;
                            end
                        end else begin
                            tsh_d   = thold_aligned;
                            tfull_d = tx_wr;
                            transmit_ready_flag_d  = 1'b1;
                            xirq_d  = 1'b1;
                            tx_st_d = FSSP_TX_ARM;
                        end
                    end
                end
                FSSP_TX_SYNC: begin
                    // copy on the falling edge inside the frame pulse
                    if (tx_fall) begin
                        tsh_d    = thold_aligned;
                        tfull_d  = tx_wr;
                        transmit_ready_flag_d   = 1'b1;
                        xirq_d   = 1'b1;
                        fsseen_d = 1'b1;
                        tx_st_d  = FSSP_TX_ARM;
                    end
                end
                FSSP_TX_ARM: begin
                    if (tx_fall && tfs_ext && !cfg_int_fsync) begin
                        fsseen_d = 1'b1;
                    end
                    if (tx_rise && fsseen_q) begin
                        fs_d     = 1'b0;
                        fsseen_d = 1'b0;
                        dout_d   = tsh_q[`FSSP_WORD_W-1];
                        tsh_d    = {tsh_q[`FSSP_WORD_W-2:0], 1'b0};
                        doe_d    = 1'b1;
                        tbits_d  = pkt_len - 1'b1;
                        tx_st_d  = FSSP_TX_SHIFT;
                    end
                end
                FSSP_TX_SHIFT: begin
                    if (tx_rise) begin
                        if (tbits_q != '0) begin
                            dout_d  = tsh_q[`FSSP_WORD_W-1];
                            tsh_d   = {tsh_q[`FSSP_WORD_W-2:0], 1'b0};
                            tbits_d = tbits_q - 1'b1;
                        end else if (!cfg_burst && tfull_q) begin
                            // continuous: next word follows with no new pulse
                            dout_d  = thold_aligned[`FSSP_WORD_W-1];
                            tsh_d   = {thold_aligned[`FSSP_WORD_W-2:0], 1'b0};
                            tbits_d = pkt_len - 1'b1;
                            tfull_d = tx_wr;
                            transmit_ready_flag_d  = 1'b1;
                            xirq_d  = 1'b1;
                        end else begin
                            doe_d   = 1'b0;
                            tx_st_d = FSSP_TX_IDLE;
                        end
                    end
                end
                default: begin
                    tx_st_d = FSSP_TX_IDLE;
                end
            endcase
        end
        tsempty_d = (tx_st_d == FSSP_TX_IDLE) || (tx_st_d == FSSP_TX_SYNC);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            tx_st_q   <= FSSP_TX_IDLE;
            thold_q   <= '0;
            tsh_q     <= '0;
            tbits_q   <= '0;
            tfull_q   <= 1'b0;
            transmit_ready_flag_q    <= `FSSP_TRANSMIT_READY_FLAG_RST;
            xirq_q    <= 1'b0;
            fsseen_q  <= 1'b0;
            fs_q      <= 1'b0;
            dout_q    <= 1'b0;
            doe_q     <= 1'b0;
            div_q     <= 1'b0;
            clkint_q  <= 1'b0;
            clkoe_q   <= 1'b0;
            fsoe_q    <= 1'b0;
            tsempty_q <= 1'b1;
        end else begin
            tx_st_q   <= tx_st_d;
            thold_q   <= thold_d;
            tsh_q     <= tsh_d;
            tbits_q   <= tbits_d;
            tfull_q   <= tfull_d;
            transmit_ready_flag_q    <= transmit_ready_flag_d;
            xirq_q    <= xirq_d;
            fsseen_q  <= fsseen_d;
            fs_q      <= fs_d;
            dout_q    <= dout_d;
            doe_q     <= doe_d;
            div_q     <= div_d;
            clkint_q  <= clkint_d;
            clkoe_q   <= clkoe_d;
            fsoe_q    <= fsoe_d;
            tsempty_q <= tsempty_d;
        end
    end

    // ----------------------------------------------------------------
    // receive side
    // ----------------------------------------------------------------
    fssp_rx_state_t rx_st_q, rx_st_d;
    fssp_word_t     rsh_q, rsh_d, rhold_q, rhold_d, push_data, pop_data;
    fssp_cnt_t      rbits_q, rbits_d;
    logic           receive_ready_flag_q, receive_ready_flag_d, rirq_q, rirq_d, ovr_q, ovr_d;
    logic           push_valid, push_ready, pop_valid, pop_ready;

    // a full buffer drops the new packet and flags overrun instead of stalling the wire
    fssp_fifo #(
        .W (`FSSP_WORD_W),
        .D (`FSSP_FIFO_DEPTH)
    ) u_rx_fifo (
        .clk       (clk),
        .rst       (rst),
        .in_valid  (push_valid),
        .in_ready  (push_ready),
        .in_data   (push_data),
        .out_valid (pop_valid),
        .out_ready (pop_ready),
        .out_data  (pop_data)
    );

    assign push_data = {rsh_q[`FSSP_WORD_W-2:0], din};
    assign pop_ready = !receive_ready_flag_q || rx_rd;

    always_comb begin
        rx_st_d    = rx_st_q;
        rsh_d      = rsh_q;
        rbits_d    = rbits_q;
        ovr_d      = ovr_q;
        push_valid = 1'b0;
        if (!rx_enable) begin
            rx_st_d = FSSP_RX_IDLE;
            ovr_d   = 1'b0;
        end else begin
            case (rx_st_q)
                FSSP_RX_IDLE: begin
                    if (rx_fall && rfs) begin
                        rx_st_d = FSSP_RX_ARM;
                    end
                end
                FSSP_RX_ARM: begin
                    if (rx_fall && !rfs) begin
                        rsh_d   = {{(`FSSP_WORD_W-1){1'b0}}, din};
                        rbits_d = pkt_len - 1'b1;
                        rx_st_d = FSSP_RX_SHIFT;
                    end
                end
                FSSP_RX_SHIFT: begin
                    if (rx_fall) begin
                        rsh_d   = push_data;
                        rbits_d = rbits_q - 1'b1;
                        if (rbits_q == 5'h01) begin
                            push_valid = 1'b1;
                            if (!push_ready) begin
                                ovr_d = 1'b1;
                            end
                            rsh_d   = '0;
                            rbits_d = pkt_len;
                            rx_st_d = cfg_burst ? FSSP_RX_IDLE : FSSP_RX_SHIFT;
                        end
                    end
                end
                default: begin
                    rx_st_d = FSSP_RX_IDLE;
                end
            endcase
        end
        rhold_d = rhold_q;
        receive_ready_flag_d  = receive_ready_flag_q;
        rirq_d  = 1'b0;
        if (rx_rd) begin
            receive_ready_flag_d = 1'b0;
        end
        // new data wins over a read in the same cycle
        if (pop_valid && pop_ready) begin
            rhold_d = pop_data;
            receive_ready_flag_d  = 1'b1;
            rirq_d  = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rx_st_q <= FSSP_RX_IDLE;
            rsh_q   <= '0;
            rbits_q <= '0;
            rhold_q <= '0;
            receive_ready_flag_q  <= `FSSP_RECEIVE_READY_FLAG_RST;
            rirq_q  <= 1'b0;
            ovr_q   <= 1'b0;
        end else begin
            rx_st_q <= rx_st_d;
            rsh_q   <= rsh_d;
            rbits_q <= rbits_d;
            rhold_q <= rhold_d;
            receive_ready_flag_q  <= receive_ready_flag_d;
            rirq_q  <= rirq_d;
            ovr_q   <= ovr_d;
        end
    end

    // ----------------------------------------------------------------
    // outputs; shift registers never reach a port
    // ----------------------------------------------------------------
    assign receive_holding_reg    = rhold_q;
    assign transmit_ready_flag    = transmit_ready_flag_q;
    assign receive_ready_flag     = receive_ready_flag_q;
    assign transmit_irq           = xirq_q;
    assign receive_irq            = rirq_q;
    assign tx_shift_empty         = tsempty_q;
    assign rx_overrun             = ovr_q;
    assign transmit_bit_clock_o   = clkint_q;
    assign transmit_bit_clock_oe  = clkoe_q;
    assign transmit_frame_sync_o  = fs_q;
    assign transmit_frame_sync_oe = fsoe_q;
    assign serial_out_pin_o       = dout_q;
    assign serial_out_pin_oe      = doe_q;
endmodule

// [hw/fssp_port_fix.sv]
`timescale 1ns/1ps

// [verification/fssp_port_props.sv]
// Purpose : concurrent checks on the serial port pins and flags
// Assumes : bound to every fssp_port; internal bit clock is clk/4
// Notes   : pin timing is only judged while the port drives the bit clock
`timescale 1ns/1ps
module fssp_port_props (
    input wire logic clk,                    // machine clock
    input wire logic rst,                    // sync reset
    input wire logic cfg_int_clock,          // internal bit clock
    input wire logic cfg_int_fsync,          // internal frame sync
    input wire logic tx_wr,                  // holding write
    input wire logic transmit_ready_flag,    // tx ready
    input wire logic receive_ready_flag,     // rx ready
    input wire logic transmit_irq,           // tx pulse
    input wire logic receive_irq,            // rx pulse
    input wire logic transmit_bit_clock_o,   // clock out
    input wire logic transmit_bit_clock_oe,  // clock driven
    input wire logic transmit_frame_sync_o,  // sync out
    input wire logic transmit_frame_sync_oe, // sync driven
    input wire logic serial_out_pin_o,       // data out
    input wire logic serial_out_pin_oe       // data driven
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    property p_clk_oe; !$past(rst) |-> transmit_bit_clock_oe == $past(cfg_int_clock); endproperty
    a_clk_oe: assert property (p_clk_oe) else $error("clock drive enable wrong");
    property p_fs_oe; !$past(rst) |-> transmit_frame_sync_oe == $past(cfg_int_fsync); endproperty
    a_fs_oe: assert property (p_fs_oe) else $error("sync drive enable wrong");
    property p_rate; transmit_bit_clock_oe && $rose(transmit_bit_clock_o) |=> transmit_bit_clock_o ##1 !transmit_bit_clock_o; endproperty
    a_rate: assert property (p_rate) else $error("bit clock faster than clk/4");
    property p_fs_w; $rose(transmit_frame_sync_o) && transmit_bit_clock_oe |-> transmit_frame_sync_o[*4] ##1 !transmit_frame_sync_o; endproperty
    a_fs_w: assert property (p_fs_w) else $error("frame pulse not one bit long");
    property p_fs_edge; $rose(transmit_frame_sync_o) && transmit_bit_clock_oe |-> $rose(transmit_bit_clock_o); endproperty
    a_fs_edge: assert property (p_fs_edge) else $error("frame pulse off rising edge");
    property p_dout; transmit_bit_clock_oe && serial_out_pin_oe && $past(serial_out_pin_oe) && $changed(serial_out_pin_o) |-> $rose(transmit_bit_clock_o); endproperty
    a_dout: assert property (p_dout) else $error("data moved off rising edge");
    property p_float; transmit_bit_clock_oe && $changed(serial_out_pin_oe) |-> $rose(transmit_bit_clock_o); endproperty
    a_float: assert property (p_float) else $error("data drive moved off rising edge");
    property p_txirq; transmit_irq |-> $rose(transmit_ready_flag) ##1 !transmit_irq; endproperty
    a_txirq: assert property (p_txirq) else $error("tx pulse without ready rise");
    property p_rxirq; receive_irq |-> receive_ready_flag ##1 !receive_irq; endproperty
    a_rxirq: assert property (p_rxirq) else $error("rx pulse without ready");
    property p_wr; tx_wr |=> !transmit_ready_flag || transmit_irq; endproperty
    a_wr: assert property (p_wr) else $error("ready not cleared by write");
endmodule
bind fssp_port fssp_port_props u_props (.clk, .rst, .cfg_int_clock, .cfg_int_fsync, .tx_wr, .transmit_ready_flag,
    .receive_ready_flag, .transmit_irq, .receive_irq, .transmit_bit_clock_o, .transmit_bit_clock_oe,
    .transmit_frame_sync_o, .transmit_frame_sync_oe, .serial_out_pin_o, .serial_out_pin_oe);

// [verification/fssp_codec_model.sv]
// Purpose : serial device on the far side of the port
// Assumes : 200 ns bit period; data changes while its clock is low
// Notes   : clock stands low between frames; released data shows the inverse
`timescale 1ns/1ps
module fssp_codec_model (
    output logic rclk,   // bit clock toward the port
    output logic rfs,    // frame sync toward the port
    output logic rdat,   // data toward the port
    input wire logic tclk, // transmit clock pin level
    input wire logic tdat, // transmit data pin
    input wire logic toe   // transmit data driven
);
    logic [15:0] got = 16'h0000;
    int          ngot = 0;
    initial {rclk, rfs, rdat} = 3'b000;
    task automatic send(input logic [15:0] w, input int n, input logic pulse);
        if (pulse) begin
            #13 rfs = 1'b1;
            #100 rclk = 1'b1;
            #100 rclk = 1'b0;
        end
        for (int i = n - 1; i >= 0; i--) begin
            #50 rfs = 1'b0;
            rdat = w[i];
            #50 rclk = 1'b1;
            #100 rclk = 1'b0;
        end
        #50 rdat = ~rdat;
    endtask
    always @(negedge tclk) begin
        if (toe === 1'b1) begin
            got <= {got[14:0], tdat};
            ngot <= ngot + 1;
        end
    end
endmodule

// [verification/fssp_port_tb_top.sv]
// Purpose : self-checking bench of the framed serial port
// Assumes : inputs change at falling clk; modes change with both sides halted
// Notes   : the far side is driven by the codec model
`timescale 1ns/1ps
module fssp_port_tb_top;
    import fssp_pkg::*;
    logic       clk = 1'b0, rst = 1'b1, tx_wr = 1'b0, rx_rd = 1'b0, tx_enable = 1'b0, rx_enable = 1'b0;
    logic       cfg_fmt_8bit = 1'b0, cfg_burst = 1'b1, cfg_int_clock = 1'b1, cfg_int_fsync = 1'b1;
    fssp_word_t tx_wdata = 16'h0000;
    fssp_word_t receive_holding_reg;
    logic       transmit_ready_flag, receive_ready_flag, transmit_irq, receive_irq, tx_shift_empty, rx_overrun;
    logic       transmit_bit_clock_o, transmit_bit_clock_oe, transmit_frame_sync_o, transmit_frame_sync_oe;
    logic       serial_out_pin_o, serial_out_pin_oe, receive_bit_clock, receive_frame_sync, serial_in_pin;
    logic       transmit_bit_clock_i, transmit_frame_sync_i;
    int         error_cnt = 0, checks_done = 0, nfs = 0, cyc = 0;
    // two-way pins: port level when driven, far side otherwise
    assign transmit_bit_clock_i = transmit_bit_clock_oe ? transmit_bit_clock_o : receive_bit_clock;
    assign transmit_frame_sync_i = transmit_frame_sync_oe ? transmit_frame_sync_o : receive_frame_sync;
    fssp_port u_dut (.*);
    fssp_codec_model u_m (.rclk(receive_bit_clock), .rfs(receive_frame_sync), .rdat(serial_in_pin),
        .tclk(transmit_bit_clock_i), .tdat(serial_out_pin_o), .toe(serial_out_pin_oe));
    always #12.5 clk = ~clk;
    always @(posedge transmit_frame_sync_o) nfs++;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            chk(1'b0, 1'b1, "timeout");
            stop_test();
        end
    end
    task automatic chk(input logic [15:0] g, input logic [15:0] e, input string m);
        checks_done++;
        if (g !== e) begin
            error_cnt++;
            $display("Error %0t %s got %h exp %h", $time, m, g, e);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic mode(input logic f8, input logic b, input logic ic);
        @(negedge clk);
        {tx_enable, rx_enable} = 2'b00;
        @(negedge clk);
        {cfg_fmt_8bit, cfg_burst, cfg_int_clock, cfg_int_fsync} = {f8, b, ic, ic};
        @(negedge clk);
        {tx_enable, rx_enable} = 2'b11;
    endtask
    task automatic strobe(input logic t, input fssp_word_t w);
        @(negedge clk);
        tx_wdata = w;
        {tx_wr, rx_rd} = {t, !t};
        @(negedge clk);
        {tx_wr, rx_rd} = 2'b00;
    endtask
    task automatic waitc(input logic s);
        for (int i = 0; i < 400; i++) begin
            @(posedge clk);
            #1;
            if ((s ? tx_shift_empty : transmit_irq) === 1'b1)
                return;
        end
        chk(1'b0, 1'b1, "wait expired");
    endtask
    task automatic txrun(input logic f8, input logic b, input fssp_word_t w, input logic two);
        mode(f8, b, 1'b1);
        nfs = 0;
        u_m.ngot = 0;
        strobe(1'b1, w);
        chk(transmit_ready_flag, 16'h0000, "ready low");
        waitc(1'b0);
        chk(transmit_ready_flag, 16'h0001, "ready high");
        if (two) begin
            strobe(1'b1, ~w);
            waitc(1'b0);
        end
        waitc(1'b1);
        chk(16'(u_m.ngot), two ? 16'h0020 : (f8 ? 16'h0008 : 16'h0010), "bit count");
        chk(u_m.got & (f8 ? 16'h00ff : 16'hffff), (two ? ~w : w) & (f8 ? 16'h00ff : 16'hffff), "tx data");
        chk(16'(nfs), 16'h0001, "frame pulses");
        $display("tx test done");
    endtask
    initial begin
        repeat (10) @(negedge clk);
        rst = 1'b0;
        repeat (4) @(negedge clk);
        chk({transmit_ready_flag, receive_ready_flag, tx_shift_empty}, 16'h0005, "reset flags");
        for (int k = 0; k < 3; k++)
            txrun(k == 2, k != 0, 16'ha5c3, k == 0);
        mode(1'b0, 1'b0, 1'b1);
        u_m.send(16'h1234, 16, 1'b1);
        u_m.send(16'hfedc, 16, 1'b0);
        repeat (8) @(negedge clk);
        chk(receive_holding_reg, 16'h1234, "rx first");
        strobe(1'b0, 16'h0000);
        repeat (2) @(negedge clk);
        chk(receive_holding_reg, 16'hfedc, "rx second");
        strobe(1'b0, 16'h0000);
        chk(receive_ready_flag, 16'h0000, "rx read");
        $display("rx continuous test done");
        mode(1'b1, 1'b1, 1'b1);
        for (int i = 0; i < 10; i++)
            u_m.send(16'h0040 + 16'(i), 8, 1'b1);
        repeat (8) @(negedge clk);
        chk(rx_overrun, 16'h0001, "overrun");
        for (int i = 0; i < 9; i++) begin
            chk(receive_holding_reg, 16'h0040 + 16'(i), "rx drain");
            strobe(1'b0, 16'h0000);
            repeat (2) @(negedge clk);
        end
        chk(receive_ready_flag, 16'h0000, "rx empty");
        $display("rx buffer test done");
        mode(1'b0, 1'b1, 1'b0);
        chk({transmit_bit_clock_oe, transmit_frame_sync_oe}, 16'h0000, "pins as inputs");
        chk(rx_overrun, 16'h0000, "overrun cleared");
        strobe(1'b1, 16'h5a3c);
        u_m.send(16'h0f0f, 16, 1'b1);
        repeat (8) @(negedge clk);
        chk(u_m.got, 16'h5a3c, "tx on outside clock");
        chk(receive_holding_reg, 16'h0f0f, "rx full duplex");
        $display("outside clock test done");
        stop_test();
    end
endmodule
